// File: core/adc_seq_pkg.sv
// Package: register map, field layout, codes and timing for the converter control block
package adc_seq_pkg;
    // ****************************************************
    // Register byte addresses
    // ****************************************************
    localparam logic [7:0] control_zero_addr  = 8'h00;
    localparam logic [7:0] ref_port_addr      = 8'h04;
    localparam logic [7:0] timing_addr        = 8'h08;
    localparam logic [7:0] result_high_addr   = 8'h0c;
    localparam logic [7:0] result_low_addr    = 8'h10;
    localparam logic [7:0] flag_enable_addr   = 8'h14;
    localparam logic [7:0] conv_sample_addr   = 8'h18;

    // ****************************************************
    // Field positions
    // ****************************************************
    localparam int ctl_on_bit       = 0;
    localparam int ctl_busy_bit     = 1;
    localparam int ctl_chan_lsb     = 2;
    localparam int ref_neg_bit      = 5;
    localparam int ref_pos_bit      = 4;
    localparam int tim_acq_lsb      = 3;
    localparam int tim_clk_lsb      = 0;
    localparam int fe_flag_bit      = 0;
    localparam int fe_enable_bit    = 1;
    localparam int fe_global_bit    = 2;

    // ****************************************************
    // Reset values and codes
    // ****************************************************
    localparam logic [3:0] split_reset_analog  = 4'h0;
    localparam logic [3:0] split_reset_digital = 4'h7;
    localparam logic [3:0] split_all_analog_max = 4'h2;
    localparam logic [2:0] acq_code_none = 3'h0;
    localparam logic [2:0] acq_code_four = 3'h2;
    localparam int acq_four_periods = 4;
    localparam int result_bits      = 12;
    localparam int post_wait_periods = 2;
    localparam int instr_cycle_clocks = 4;
    localparam int post_abort_clocks = 2 * instr_cycle_clocks;

    typedef enum logic [2:0] {
        st_idle    = 3'b000,
        st_acquire = 3'b001,
        st_convert = 3'b010,
        st_settle  = 3'b011,
        st_rewait  = 3'b100
    } conv_state_t;
endpackage

// File: core/adc_sequencer_config.sv
// Converter sequencer with AHB-Lite register slave
//
// Chosen here: the register addresses and the AHB-Lite register port.
`timescale 1ns/10ps

module adc_sequencer_config
    import adc_seq_pkg::*;
#(
    parameter int channels = 13
) (
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic      [31:0]           hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    input  wire logic                  portb_analog_reset_fuse,
    input  wire logic                  sample_bit,
    output logic                       neg_ref_select,
    output logic                       pos_ref_select,
    output logic      [channels-1:0]   pin_analog_enable,
    output logic      [3:0]            channel_select,
    output logic                       sample_hold,
    output logic                       conv_irq
);
    // ****************************************************
    // Registers
    // ****************************************************
    logic [5:0]  conv_reference_port_reg;
    logic [3:0]  chan;
    logic        conv_on;
    logic        busy;
    logic [2:0]  acquisition_time_code;
    logic [2:0]  clk_code;
    logic        conv_done_flag;
    logic        conv_done_enable;
    logic        global_irq_enable;
    logic [11:0] result;
    logic [11:0] shift;
    logic [3:0]  bit_left;
    logic [7:0]  tad_div;
    logic [7:0]  wait_cnt;
    logic        fuse_taken;
    conv_state_t state;

    // ****************************************************
    // Bus address phase capture
    // ****************************************************
    logic        wr_pend;
    logic [7:0]  wr_addr;
    wire         take = hsel && hready && htrans[1];
    wire         wr_now = wr_pend;
    wire         wr_ctl = wr_now && wr_addr == control_zero_addr;
    wire         wr_ref = wr_now && wr_addr == ref_port_addr;
    wire         wr_tim = wr_now && wr_addr == timing_addr;
    wire         wr_rh  = wr_now && wr_addr == result_high_addr;
    wire         wr_rl  = wr_now && wr_addr == result_low_addr;
    wire         wr_fe  = wr_now && wr_addr == flag_enable_addr;
    wire         clear_busy = wr_ctl && !hwdata[ctl_busy_bit];
    wire         set_busy = wr_ctl && hwdata[ctl_busy_bit] && hwdata[ctl_on_bit];

    // Bit period: (clk_code+1)*2 system clocks
    wire [7:0]   tad_len = {4'h0, clk_code, 1'b0} + 8'h02;
    wire         tad_tick = tad_div == 8'h00;
    // Divider restarts at start so acquisition and bit timing do not depend on divider phase
    wire         start_now = set_busy && (state == st_idle || (state == st_rewait && wait_cnt == 8'h00));
    wire [7:0]   acq_len = (acquisition_time_code == acq_code_four) ? 8'(acq_four_periods) :
                           (acquisition_time_code == acq_code_none) ? 8'h00 : {4'h0, acquisition_time_code, 1'b0};
    wire         done_now = state == st_convert && tad_tick && bit_left == 4'h0 && !clear_busy;

    wire [31:0]  rd_mux =
        (wr_addr == control_zero_addr) ? {26'h0, chan, busy, conv_on} :
        (wr_addr == ref_port_addr)     ? {26'h0, conv_reference_port_reg} :
        (wr_addr == timing_addr)       ? {26'h0, acquisition_time_code, clk_code} :
        (wr_addr == result_high_addr)  ? {28'h0, result[11:8]} :
        (wr_addr == result_low_addr)   ? {24'h0, result[7:0]} :
        (wr_addr == flag_enable_addr)  ? {29'h0, global_irq_enable, conv_done_enable, conv_done_flag} :
        32'h0;

    logic rd_pend;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= take && hwrite;
            rd_pend <= take && !hwrite;
            if (take) begin
                wr_addr <= haddr[7:0];
            end
        end
    end

    // Read data registered one cycle after the data phase begins; hreadyout drops for one wait state on each read
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata    <= 32'h0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= !(take && !hwrite);
            hrdata    <= rd_pend ? rd_mux : 32'h0;
        end
    end

    // ****************************************************
    // Configuration registers
    // ****************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            conv_reference_port_reg <= 6'h0;
            chan <= 4'h0;
            conv_on <= 1'b0;
            acquisition_time_code <= 3'h0;
            clk_code <= 3'h0;
            conv_done_enable <= 1'b0;
            global_irq_enable <= 1'b0;
            fuse_taken <= 1'b0;
        end else begin
            fuse_taken <= 1'b1;
            if (!fuse_taken) begin
                conv_reference_port_reg[3:0] <= portb_analog_reset_fuse ? split_reset_analog
                                                                        : split_reset_digital;
            end else if (wr_ref) begin
                conv_reference_port_reg <= hwdata[5:0];
            end
            if (wr_ctl) begin
                chan <= hwdata[ctl_chan_lsb +: 4];
                conv_on <= hwdata[ctl_on_bit];
            end
            if (wr_tim) begin
                acquisition_time_code <= hwdata[tim_acq_lsb +: 3];
                clk_code <= hwdata[tim_clk_lsb +: 3];
            end
            if (wr_fe) begin
                conv_done_enable <= hwdata[fe_enable_bit];
                global_irq_enable <= hwdata[fe_global_bit];
            end
        end
    end

    // Done flag: hardware set wins over software clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            conv_done_flag <= 1'b0;
        end else if (done_now) begin
            conv_done_flag <= 1'b1;
        end else if (wr_fe) begin
            conv_done_flag <= hwdata[fe_flag_bit];
        end
    end

    // ****************************************************
    // Result pair: no reset, survives ordinary resets
    // ****************************************************
    always_ff @(posedge hclk) begin
        if (done_now) begin
            result <= {shift[10:0], sample_bit};
        end else if (wr_rh) begin
            result[11:8] <= hwdata[3:0];
        end else if (wr_rl) begin
            result[7:0] <= hwdata[7:0];
        end
    end

    // ****************************************************
    // Sequencer
    // ****************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= st_idle;
            busy <= 1'b0;
            tad_div <= 8'h00;
            bit_left <= 4'h0;
            wait_cnt <= 8'h00;
            shift <= 12'h0;
        end else begin
            tad_div <= (tad_tick || start_now) ? tad_len - 8'h01 : tad_div - 8'h01;
            unique case (state)
                st_idle, st_rewait: begin
                    if (state == st_rewait && wait_cnt != 8'h00) begin
                        wait_cnt <= wait_cnt - 8'h01;
                    end else if (set_busy) begin
                        busy <= 1'b1;
                        wait_cnt <= acq_len;
                        state <= st_acquire;
                    end else begin
                        state <= st_idle;
                    end
                end
                st_acquire: begin
                    if (clear_busy) begin
                        busy <= 1'b0;
                        wait_cnt <= 8'(post_abort_clocks);
                        state <= st_rewait;
                    end else if (tad_tick) begin
                        if (wait_cnt == 8'h00) begin
                            bit_left <= 4'(result_bits - 1);
                            state <= st_convert;
                        end else begin
                            wait_cnt <= wait_cnt - 8'h01;
                        end
                    end
                end
                st_convert: begin
                    if (clear_busy) begin
                        busy <= 1'b0;
                        wait_cnt <= 8'(post_abort_clocks);
                        state <= st_rewait;
                    end else if (tad_tick) begin
                        shift <= {shift[10:0], sample_bit};
                        bit_left <= bit_left - 4'h1;
                        if (done_now) begin
                            busy <= 1'b0;
                            wait_cnt <= 8'(post_wait_periods);
                            state <= st_settle;
                        end
                    end
                end
                st_settle: begin
                    if (tad_tick) begin
                        if (wait_cnt == 8'h01) begin
                            wait_cnt <= 8'(post_abort_clocks);
                            state <= st_rewait;
                        end else begin
                            wait_cnt <= wait_cnt - 8'h01;
                        end
                    end
                end
                default: state <= st_idle;
            endcase
        end
    end

    // ****************************************************
    // Pin side outputs
    // ****************************************************
    genvar g;
    generate
        for (g = 0; g < channels; g++) begin : g_split
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    pin_analog_enable[g] <= 1'b1;
                end else begin
                    // Highest channel goes digital first from code 0011
                    pin_analog_enable[g] <= conv_reference_port_reg[3:0] <= split_all_analog_max ||
                        (32'(g) < 32'(channels) - (32'(conv_reference_port_reg[3:0]) - 32'd2));
                end
            end
        end
    endgenerate

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            neg_ref_select <= 1'b0;
            pos_ref_select <= 1'b0;
            channel_select <= 4'h0;
            sample_hold <= 1'b0;
            conv_irq <= 1'b0;
        end else begin
            neg_ref_select <= conv_reference_port_reg[ref_neg_bit];
            pos_ref_select <= conv_reference_port_reg[ref_pos_bit];
            channel_select <= chan;
            sample_hold <= state == st_convert;
            conv_irq <= conv_done_flag && conv_done_enable && global_irq_enable;
        end
    end

    // ****************************************************
    // Checks
    // ****************************************************
    sequence busy_done_s;
        state == st_convert ##0 done_now && !clear_busy;
    endsequence

    property done_clears_p;
        @(posedge hclk) disable iff (!hresetn)
        busy_done_s |=> !busy && conv_done_flag && state == st_settle;
    endproperty
    done_clears_busy_a: assert property (done_clears_p) else $error("done did not clear busy");

    abort_keeps_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (state == st_convert && clear_busy) |=> state == st_rewait && $stable(result))
        else $error("abort changed result");

    irq_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
        conv_irq |-> $past(conv_done_flag && conv_done_enable && global_irq_enable))
        else $error("irq without enables");

    ref_follow_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $changed(conv_reference_port_reg[ref_neg_bit]) |=> neg_ref_select == $past(conv_reference_port_reg[ref_neg_bit]))
        else $error("neg ref mismatch");

    upper_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (rd_pend && wr_addr == ref_port_addr) |=> hrdata[7:6] == 2'b00)
        else $error("upper bits nonzero");

    acq_delay_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (state == st_idle && set_busy && acquisition_time_code == acq_code_four) |=> state == st_acquire[*8])
        else $error("acquisition too short");

    settle_gap_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(state == st_settle) |=> state != st_acquire [*4])
        else $error("gap too short");

    rewait_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(state == st_rewait) |-> (state == st_rewait) [*8])
        else $error("restart wait too short");

    all_analog_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (conv_reference_port_reg[3:0] <= split_all_analog_max) |=> &pin_analog_enable)
        else $error("split wrong");
endmodule

// File: verification/analog_pin_model.sv
// Stand-in for the analog pins and comparator behind the converter
`timescale 1ns/10ps
module analog_pin_model (
    input  wire logic hclk,
    input  wire logic sample_hold,
    input  wire logic level,
    output logic      sample_bit
);
    logic wobble = 1'b0;

    // Comparator output is meaningless outside a conversion, so it churns there
    always @(posedge hclk) begin
        wobble <= ~wobble;
    end
    assign sample_bit = sample_hold ? level : wobble;
endmodule

// File: verification/tb_top.sv
// Self-checking bench: register map, conversion timing, abort and reset behaviour
`timescale 1ns/10ps
module tb_top
    import adc_seq_pkg::*;
;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        fuse = 1'b1;
    logic        level = 1'b1;
    logic        rd_active = 1'b0;
    logic [31:0] hrdata;
    logic        hreadyout, hresp, sample_bit, neg_ref_select, pos_ref_select, sample_hold, conv_irq;
    logic [12:0] pin_analog_enable;
    logic [3:0]  channel_select;
    logic [3:0]  chan;
    logic [31:0] exp_q[$];
    string       name_q[$];
    int          mismatches = 0;
    int          samples_checked = 0;

    adc_sequencer_config dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .portb_analog_reset_fuse(fuse), .sample_bit(sample_bit),
        .neg_ref_select(neg_ref_select), .pos_ref_select(pos_ref_select), .pin_analog_enable(pin_analog_enable),
        .channel_select(channel_select), .sample_hold(sample_hold), .conv_irq(conv_irq));
    analog_pin_model pins (.hclk(hclk), .sample_hold(sample_hold), .level(level), .sample_bit(sample_bit));

    always #2 hclk = ~hclk;

    // ****************************************************
    // Checking and closing
    // ****************************************************
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic timeout;
        mismatches++;
        $display("FAIL wait expected response seen none");
        tally_and_finish();
    endtask

    // Read data is judged here, against the oldest note left by the driver
    always @(posedge hclk) begin
        if (rd_active && hreadyout === 1'b1 && exp_q.size() > 0) begin
            check(name_q.pop_front(), exp_q.pop_front(), hrdata);
            check("hresp", 32'h0, {31'h0, hresp});
        end
    end

    function automatic logic [12:0] mask(input logic [3:0] c);
        return (c <= split_all_analog_max) ? 13'h1fff : 13'h1fff >> (c - split_all_analog_max);
    endfunction

    // ****************************************************
    // Bus master
    // ****************************************************
    task automatic wait_ready;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            @(posedge hclk);
            n++;
            if (n > 64) timeout();
        end
    endtask

    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        wait_ready();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        rd_active <= ~w;
        wait_ready();
        rd_active <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        exp_q.push_back(e);
        name_q.push_back(nm);
        bus(a, 1'b0, 32'h0);
    endtask

    task automatic quiet(input int n);
        repeat (n) begin
            @(posedge hclk);
            check("irq_quiet", 32'h0, {31'h0, conv_irq});
        end
    endtask

    // One full conversion; n counts edges from the busy readback to the interrupt
    task automatic convert(input logic [2:0] acq, input logic [2:0] ck, input logic lv, output int n);
        level <= lv;
        wr(timing_addr, {26'h0, acq, ck});
        wr(control_zero_addr, {26'h0, chan, 2'b11});
        chk_rd(control_zero_addr, {26'h0, chan, 2'b11}, "busy_set");
        check("chan", {28'h0, chan}, {28'h0, channel_select});
        n = 0;
        while (conv_irq !== 1'b1) begin
            @(posedge hclk);
            n++;
            if (n > 2000) timeout();
        end
        chk_rd(result_high_addr, {28'h0, {4{lv}}}, "result_high");
        chk_rd(result_low_addr, {24'h0, {8{lv}}}, "result_low");
        chk_rd(control_zero_addr, {26'h0, chan, 2'b01}, "busy_clear");
        chk_rd(flag_enable_addr, 32'h7, "flag_set");
        wr(flag_enable_addr, 32'h6);
        repeat (2) @(posedge hclk);
        check("irq_clear", 32'h0, {31'h0, conv_irq});
        repeat (post_wait_periods * 8 + post_abort_clocks) @(posedge hclk);
    endtask

    // ****************************************************
    // Main sequence
    // ****************************************************
    initial begin
        int code, d0, d4, d8, d12;
        logic [31:0] v;
        v = $urandom(62416);
        chan = 4'($urandom_range(12));
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (3) @(posedge hclk);
        check("reset_mask", 32'h1fff, {19'h0, pin_analog_enable});
        chk_rd(ref_port_addr, 32'h0, "reset_split");
        for (code = 0; code < 64; code++) begin
            v = ($urandom() & 32'hffff_ffc0) | 32'(code);
            wr(ref_port_addr, v);
            repeat (2) @(posedge hclk);
            check("neg_ref", {31'h0, v[ref_neg_bit]}, {31'h0, neg_ref_select});
            check("pos_ref", {31'h0, v[ref_pos_bit]}, {31'h0, pos_ref_select});
            check("analog_mask", {19'h0, mask(v[3:0])}, {19'h0, pin_analog_enable});
            chk_rd(ref_port_addr, {26'h0, v[5:0]}, "ref_port_reg");
        end
        wr(8'h1c, $urandom());
        chk_rd(8'h1c, 32'h0, "unmapped");
        wr(flag_enable_addr, 32'h6);
        convert(acq_code_none, 3'h0, 1'b1, d0);
        convert(acq_code_four, 3'h0, 1'b0, d4);
        check("acq_extra", 32'(2 * acq_four_periods), 32'(d4 - d0));
        // Code 011 gives six periods, clock code 2 a six-clock period
        convert(3'h3, 3'h2, 1'b0, d12);
        check("acq_other", 32'((2 * 3 + result_bits + 1) * 6 - (result_bits + 1) * 2), 32'(d12 - d0));
        convert(acq_code_none, 3'h1, 1'b1, d8);
        // One start tick plus twelve bit periods, each two clocks longer
        check("bit_periods", 32'(2 * (result_bits + 1)), 32'(d8 - d0));
        wr(flag_enable_addr, 32'h2);
        wr(timing_addr, 32'h0);
        wr(control_zero_addr, {26'h0, chan, 2'b11});
        quiet(d0 + 20);
        chk_rd(flag_enable_addr, 32'h3, "flag_masked");
        wr(flag_enable_addr, 32'h7);
        repeat (3) @(posedge hclk);
        check("irq_global", 32'h1, {31'h0, conv_irq});
        wr(flag_enable_addr, 32'h6);
        repeat (40) @(posedge hclk);
        level <= 1'b0;
        wr(timing_addr, {26'h0, acq_code_four, 3'h1});
        wr(control_zero_addr, {26'h0, chan, 2'b11});
        repeat (20) @(posedge hclk);
        wr(control_zero_addr, {26'h0, chan, 2'b01});
        quiet(100);
        chk_rd(result_low_addr, 32'hff, "abort_keep");
        chk_rd(control_zero_addr, {26'h0, chan, 2'b01}, "abort_busy");
        hresetn <= 1'b0;
        fuse <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (3) @(posedge hclk);
        check("fuse_mask", 32'h00ff, {19'h0, pin_analog_enable});
        chk_rd(result_high_addr, 32'hf, "keep_high");
        chk_rd(result_low_addr, 32'hff, "keep_low");
        tally_and_finish();
    end
endmodule
